/* core/mbs_pkg.sv */
package mbs_pkg;
	localparam int VA_W = 24;
	localparam int PA_W = 25;
	localparam int TLB_N = 8;
	localparam int TLB_IW = 3;
	localparam int PAGE_W = 9;
	localparam int VPN_W = VA_W - PAGE_W;
	localparam int PFN_W = PA_W - PAGE_W;
	// pte low word field positions
	localparam int PTE_V_BIT = 0;
	localparam int PTE_PL_LO = 1;
	localparam int PTE_R_BIT = 3;
	localparam int PTE_M_BIT = 4;
	localparam logic [3:0] ST_RMW_READ = 4'hb;
	localparam logic DIR_READ = 1'b0;
	localparam logic DIR_WRITE = 1'b1;
	localparam int WALK_WORDS = 4;
	localparam logic [1:0] CNT_ZERO = 2'h0;
	localparam logic [24:0] PTB_RESET = 25'h0000000;
	localparam int T32_HOLD = 3;

	typedef enum logic [3:0] {
		MBS_IDLE = 4'h0,
		MBS_XLAT = 4'h1,
		MBS_XFER = 4'h3,
		MBS_WAIT = 4'h2,
		MBS_END = 4'h6,
		MBS_WPHOLD = 4'h7,
		MBS_ABORT = 4'h5,
		MBS_GAP = 4'h4,
		MBS_WALK_T1 = 4'hc,
		MBS_WALK_T2 = 4'hd,
		MBS_WALK_T3 = 4'hf,
		MBS_WALK_T4 = 4'he,
		MBS_RESUME = 4'ha
	} mbs_state_e;

	typedef struct packed {
		logic [VA_W-1:0] vaddr;
		logic dir;
		logic [3:0] status;
		logic user;
	} mbs_req_s;

	typedef struct packed {
		logic valid;
		logic [VPN_W-1:0] vpn;
		logic [PFN_W-1:0] pfn;
		logic [1:0] prot;
		logic modified;
	} mbs_tlb_s;

	// protection level 0..3: 0 and 1 none for user, 2 read user, 3 rw user(supervisor always rw)
	function automatic logic mbs_allowed(input logic [1:0] pl, input logic user,
		input logic wr);
		logic ok;
		ok = 1'b1;
		if (user) begin
			ok = (pl == 2'h3) || (pl == 2'h2 && !wr);
		end
		return ok;
	endfunction : mbs_allowed
endpackage : mbs_pkg

/* core/mbs_tlb.sv */
`timescale 1ns/100ps
module mbs_tlb
	import mbs_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// lookup
	input wire logic [VPN_W-1:0] look_vpn,
	output logic look_hit,
	output mbs_tlb_s look_entry,
	// fill
	input wire logic fill_en,
	input mbs_tlb_s fill_entry
);
	mbs_tlb_s ent_q [TLB_N];
	logic [TLB_IW-1:0] victim_q;
	logic [TLB_N-1:0] match;

	genvar gi;
	generate
		for (gi = 0; gi < TLB_N; gi++) begin : g_cmp
			assign match[gi] = ent_q[gi].valid && ent_q[gi].vpn == look_vpn;
		end
	endgenerate

	always_comb begin
		look_hit = 1'b0;
		look_entry = '0;
		for (int i = 0; i < TLB_N; i++) begin
			if (match[i]) begin
				look_hit = 1'b1;
				look_entry = ent_q[i];
			end
		end
	end

	// a refill of a present vpn overwrites it, avoiding duplicate hits
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < TLB_N; i++) begin
				ent_q[i] <= '0;
			end
			victim_q <= '0;
		end else if (fill_en) begin
			if (look_hit) begin
				for (int i = 0; i < TLB_N; i++) begin
					if (match[i]) begin
						ent_q[i] <= fill_entry;
					end
				end
			end else begin
				ent_q[victim_q] <= fill_entry;
				victim_q <= victim_q + 1'b1;
			end
		end
	end
endmodule : mbs_tlb

/* core/mbs_seq.sv */
`timescale 1ns/100ps
// Summary of operation
// - cpu cycle: address, translation, transfer, wait, end; five clocks minimum
// - in address state latch virtual address, direction, status and privilege
// - hit and allowed: drive physical address, pulse strobe in translation state
// - hit but forbidden: pulse abort, no strobe
// - miss or first write to clean page: assert takeover, start own cycles
// - float low address/data pins from first transfer through end state
// - 16-bit mode: hold upper address from translation through end state
// - 32-bit mode: drive upper address only in translation; latched externally
// - own cycles only nested inside a cpu cycle after takeover
// - first write to clean page walks tables and sets modified bit
// - wait one clock after takeover, then four back-to-back 16-bit reads
// - no idle clocks between own cycles unless hold requested
// - drive direction during walk; cpu holds status and privilege
// - clock after last walk end: drop takeover, drive address, pulse strobe
// - write hit to protected clean page: takeover two clocks, abort delayed one
// - low word first; invalid or forbidden entry stops walk, aborts
// - referenced/modified update writes low word back before high word
// - at most two words written per translation
// - ready low repeats wait state, high goes to end state
// - cpu cycles watch ready only in 16-bit mode; 32-bit frees after three
// - abort is a one-clock low pulse
// - width select latched at reset release: high 16-bit, low 32-bit
// - status 1011 counts as a write for protection
// - direction: read 0, write 1
module mbs_seq
	import mbs_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// cpu side
	input wire logic addr_strobe_n,
	input wire logic [VA_W-1:0] cpu_vaddr,
	input wire logic transfer_direction_in,
	input wire logic [3:0] cycle_status,
	input wire logic user_mode,
	input wire logic ready,
	input wire logic hold_req,
	input wire logic bus_width_select,
	// table base
	input wire logic [PA_W-1:0] table_base,
	// bus data in
	input wire logic [15:0] low_addr_data_in,
	// bus outputs
	output logic [15:0] low_addr_data_out,
	output logic low_addr_data_oe,
	output logic [8:0] upper_address_lines,
	output logic upper_address_oe,
	output logic transfer_direction_out,
	output logic transfer_direction_oe,
	output logic phys_addr_strobe_n,
	output logic bus_takeover,
	output logic reset_abort_out_n,
	output logic mode_16bit
);
	mbs_state_e st_q;
	mbs_req_s req_q;
	logic width_seen_q;
	logic [1:0] word_q;
	logic wr_phase_q;
	logic [15:0] lo_q;
	logic [15:0] l1_lo_q;
	logic [1:0] wcnt_q;
	logic [1:0] gap_q;
	logic hit;
	mbs_tlb_s hent;
	logic is_wr;
	logic fill_en;
	mbs_tlb_s fill_e;
	logic [PA_W-1:0] walk_addr;
	logic pte_bad;
	logic need_upd;
	logic [15:0] upd_word;
	logic [PA_W-1:0] pa;
	logic [PA_W-1:0] pa_walk;

	mbs_tlb u_tlb (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.look_vpn(req_q.vaddr[VA_W-1:PAGE_W]),
		.look_hit(hit),
		.look_entry(hent),
		.fill_en(fill_en),
		.fill_entry(fill_e)
	);

	assign is_wr = req_q.dir == DIR_WRITE || req_q.status == ST_RMW_READ;
	assign pa = {hent.pfn, req_q.vaddr[PAGE_W-1:0]};
	// level-1 index from top vaddr bits, level-2 from l1 frame plus middle bits
	assign walk_addr = word_q[1] ?
		{l1_lo_q[15:PAGE_W], 9'h000, req_q.vaddr[PAGE_W+6:PAGE_W], word_q[0], 1'b0} :
		{table_base[PA_W-1:11], 1'b0, req_q.vaddr[VA_W-1:VA_W-8], word_q[0], 1'b0};
	assign pte_bad = !lo_q[PTE_V_BIT] ||
		!mbs_allowed(lo_q[PTE_PL_LO+1:PTE_PL_LO], req_q.user, is_wr);
	// low word just read: R always on both levels, M only on level-2 writes
	assign need_upd = !low_addr_data_in[PTE_R_BIT] ||
		(word_q[1] && is_wr && !low_addr_data_in[PTE_M_BIT]);
	always_comb begin
		upd_word = lo_q;
		upd_word[PTE_R_BIT] = 1'b1;
		if (word_q[1] && is_wr) begin
			upd_word[PTE_M_BIT] = 1'b1;
		end
	end

	// width strap caught by the first clock after release
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			width_seen_q <= 1'b0;
			mode_16bit <= 1'b0;
		end else if (!width_seen_q) begin
			width_seen_q <= 1'b1;
			mode_16bit <= bus_width_select;
		end
	end

	// sequencer
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= MBS_IDLE;
			req_q <= '0;
			word_q <= '0;
			wr_phase_q <= 1'b0;
			lo_q <= '0;
			l1_lo_q <= '0;
			gap_q <= CNT_ZERO;
		end else begin
			unique case (st_q)
				MBS_IDLE: begin
					if (!addr_strobe_n && width_seen_q) begin
						req_q <= '{cpu_vaddr, transfer_direction_in, cycle_status,
							user_mode};
						st_q <= MBS_XLAT;
					end
				end
				MBS_XLAT: begin
					if (!hit || (is_wr && !hent.modified)) begin
						if (hit && is_wr && !mbs_allowed(hent.prot, req_q.user, 1'b1)) begin
							st_q <= MBS_WPHOLD;
						end else begin
							word_q <= '0;
							gap_q <= CNT_ZERO;
							st_q <= MBS_GAP;
						end
					end else if (!mbs_allowed(hent.prot, req_q.user, is_wr)) begin
						st_q <= MBS_ABORT;
					end else begin
						gap_q <= CNT_ZERO;
						st_q <= MBS_XFER;
					end
				end
				MBS_WPHOLD: st_q <= MBS_ABORT;
				MBS_ABORT: st_q <= MBS_IDLE;
				// first entry spends one extra clock after takeover
				MBS_GAP: begin
					gap_q <= 2'h1;
					if (!hold_req && gap_q != CNT_ZERO) begin
						st_q <= MBS_WALK_T1;
					end
				end
				MBS_WALK_T1: st_q <= MBS_WALK_T2;
				MBS_WALK_T2: st_q <= MBS_WALK_T3;
				MBS_WALK_T3: begin
					if (ready) begin
						st_q <= MBS_WALK_T4;
						if (!wr_phase_q && !word_q[0]) begin
							lo_q <= low_addr_data_in;
						end
					end
				end
				MBS_WALK_T4: begin
					if (wr_phase_q) begin
						wr_phase_q <= 1'b0;
						word_q <= word_q + 2'h1;
						st_q <= hold_req ? MBS_GAP : MBS_WALK_T1;
					end else if (!word_q[0]) begin
						if (pte_bad) begin
							st_q <= MBS_ABORT;
						end else begin
							if (!word_q[1]) begin
								l1_lo_q <= lo_q;
							end
							wr_phase_q <= need_upd;
							word_q <= need_upd ? word_q : word_q + 2'h1;
							st_q <= hold_req ? MBS_GAP : MBS_WALK_T1;
						end
					end else if (word_q == 2'(WALK_WORDS - 1)) begin
						st_q <= MBS_RESUME;
					end else begin
						word_q <= word_q + 2'h1;
						st_q <= hold_req ? MBS_GAP : MBS_WALK_T1;
					end
				end
				// strobe already issued at the last walk end, so this stands for transfer
				MBS_RESUME: begin
					gap_q <= 2'h1;
					st_q <= MBS_WAIT;
				end
				MBS_XFER: begin
					gap_q <= gap_q + 2'h1;
					st_q <= MBS_WAIT;
				end
				MBS_WAIT: begin
					if (mode_16bit ? ready : gap_q == 2'(T32_HOLD - 2)) begin
						st_q <= MBS_END;
					end
					gap_q <= gap_q + 2'h1;
				end
				MBS_END: st_q <= MBS_IDLE;
				default: st_q <= MBS_IDLE;
			endcase
		end
	end

	// tlb refill after a clean walk
	assign fill_en = st_q == MBS_WALK_T4 && word_q == 2'(WALK_WORDS - 1) && !wr_phase_q;
	always_comb begin
		fill_e.valid = 1'b1;
		fill_e.vpn = req_q.vaddr[VA_W-1:PAGE_W];
		fill_e.pfn = {low_addr_data_in[8:0], lo_q[15:PAGE_W]};
		fill_e.prot = lo_q[PTE_PL_LO+1:PTE_PL_LO];
		fill_e.modified = lo_q[PTE_M_BIT] | is_wr;
	end
	// tlb not yet filled at the last walk end: address comes from the fill word
	assign pa_walk = {fill_e.pfn, req_q.vaddr[PAGE_W-1:0]};

	// pin drive, registered from next state decode
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			low_addr_data_out <= '0;
			low_addr_data_oe <= 1'b0;
			upper_address_lines <= '0;
			upper_address_oe <= 1'b0;
			transfer_direction_out <= DIR_READ;
			transfer_direction_oe <= 1'b0;
			phys_addr_strobe_n <= 1'b1;
			bus_takeover <= 1'b0;
			reset_abort_out_n <= 1'b1;
		end else begin
			phys_addr_strobe_n <= 1'b1;
			reset_abort_out_n <= 1'b1;
			low_addr_data_oe <= 1'b0;
			if (st_q == MBS_IDLE) begin
				upper_address_oe <= 1'b0;
			end
			if (st_q == MBS_XLAT) begin
				if (!hit || (is_wr && !hent.modified)) begin
					bus_takeover <= 1'b1;
				end else if (mbs_allowed(hent.prot, req_q.user, is_wr)) begin
					low_addr_data_out <= pa[15:0];
					low_addr_data_oe <= 1'b1;
					upper_address_lines <= pa[PA_W-1:16];
					upper_address_oe <= 1'b1;
					phys_addr_strobe_n <= 1'b0;
				end else begin
					reset_abort_out_n <= 1'b0;
				end
			end
			if (st_q == MBS_WPHOLD) begin
				reset_abort_out_n <= 1'b0;
			end
			if (st_q == MBS_ABORT) begin
				bus_takeover <= 1'b0;
			end
			if ((st_q == MBS_GAP && !hold_req && gap_q != CNT_ZERO) || (st_q == MBS_WALK_T4 &&
				!(word_q[0] && !wr_phase_q && word_q == 2'(WALK_WORDS - 1)) &&
				!(!wr_phase_q && !word_q[0] && pte_bad) && !hold_req)) begin
				transfer_direction_oe <= 1'b1;
				transfer_direction_out <= (st_q == MBS_WALK_T4 && !wr_phase_q &&
					!word_q[0] && need_upd) ? DIR_WRITE : DIR_READ;
				low_addr_data_out <= walk_addr[15:0];
				low_addr_data_oe <= 1'b1;
				upper_address_lines <= walk_addr[PA_W-1:16];
				upper_address_oe <= 1'b1;
				phys_addr_strobe_n <= 1'b0;
			end
			if (st_q == MBS_WALK_T1 && wr_phase_q) begin
				low_addr_data_out <= upd_word;
				low_addr_data_oe <= 1'b1;
			end
			if (st_q == MBS_WALK_T3 && wr_phase_q) begin
				low_addr_data_oe <= 1'b1;
			end
			if (st_q == MBS_WALK_T4 && !wr_phase_q && !word_q[0] && pte_bad) begin
				bus_takeover <= 1'b0;
				transfer_direction_oe <= 1'b0;
				reset_abort_out_n <= 1'b0;
			end
			if (fill_en) begin
				bus_takeover <= 1'b0;
				transfer_direction_oe <= 1'b0;
				low_addr_data_out <= pa_walk[15:0];
				low_addr_data_oe <= 1'b1;
				upper_address_lines <= pa_walk[PA_W-1:16];
				upper_address_oe <= 1'b1;
				phys_addr_strobe_n <= 1'b0;
			end
			if ((st_q == MBS_XFER || st_q == MBS_RESUME) && !mode_16bit) begin
				upper_address_oe <= 1'b0;
			end
		end
	end

	abort_short_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		!reset_abort_out_n |=> reset_abort_out_n)
		else $error("abort pulse longer than one clock");
	abort_pulse_one_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		$fell(reset_abort_out_n) |=> reset_abort_out_n)
		else $error("abort wider than one clock");
	abort_no_strobe_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		!reset_abort_out_n |-> phys_addr_strobe_n)
		else $error("strobe with abort");
	hit_strobe_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		st_q == MBS_XLAT && hit && !(is_wr && !hent.modified) &&
		mbs_allowed(hent.prot, req_q.user, is_wr) |=> !phys_addr_strobe_n && upper_address_oe)
		else $error("hit did not strobe");
	miss_takeover_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		st_q == MBS_XLAT && !hit |=> bus_takeover)
		else $error("miss without takeover");
	wp_takeover_two_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		$rose(bus_takeover) && st_q == MBS_WPHOLD |->
		##1 bus_takeover && !reset_abort_out_n ##1 !bus_takeover)
		else $error("write protect timing wrong");
	walk_gap_one_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		$rose(bus_takeover) && st_q == MBS_GAP && !hold_req |=> ##1 st_q == MBS_WALK_T1)
		else $error("walk did not start after one clock");
	low_float_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		st_q inside {MBS_WAIT, MBS_END} |-> !low_addr_data_oe)
		else $error("low pins driven in transfer");
	upper_32_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		!mode_16bit && st_q == MBS_WAIT |-> !upper_address_oe)
		else $error("upper lines driven in 32-bit transfer");
	dir_walk_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		st_q inside {MBS_WALK_T2, MBS_WALK_T3} |-> transfer_direction_oe)
		else $error("direction not driven in walk");
	cover property (@(posedge sys_clk) disable iff (!nrst) st_q == MBS_XLAT ##1 st_q == MBS_XFER);
	cover property (@(posedge sys_clk) disable iff (!nrst) st_q == MBS_RESUME);
	cover property (@(posedge sys_clk) disable iff (!nrst) $fell(reset_abort_out_n));
	cover property (@(posedge sys_clk) disable iff (!nrst) st_q == MBS_WALK_T3 && wr_phase_q);
endmodule : mbs_seq

/* dv/mbs_mem_model.sv */
`timescale 1ns/100ps
module mbs_mem_model
	import mbs_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// device bus outputs
	input wire logic bus_takeover,
	input wire logic phys_addr_strobe_n,
	input wire logic transfer_direction_out,
	input wire logic low_addr_data_oe,
	input wire logic [15:0] low_addr_data_out,
	// answers to the device
	output logic ready,
	output logic [15:0] low_addr_data_in
);
	logic [15:0] words [4];
	logic [15:0] cur;
	logic [15:0] last_wr;
	logic [3:0] waits;
	logic [3:0] cnt;
	logic busy;
	int idx;
	int n_rd;
	int n_wr;

	// walk words are served in read order, not by address
	task automatic load(input logic [15:0] w0, w1, w2, w3, input logic [3:0] w);
		words = '{w0, w1, w2, w3};
		waits = w;
		idx = 0;
		n_rd = 0;
		n_wr = 0;
		last_wr = 16'h0000;
	endtask : load

	initial load(16'h0000, 16'h0000, 16'h0000, 16'h0000, 4'h0);

	// a released bus shows the inverse, never a stale copy
	assign low_addr_data_in = busy ? cur : ~cur;
	assign ready = (cnt == 4'h0);

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= 4'h0;
			busy <= 1'b0;
			cur <= 16'h0000;
		end else if (!phys_addr_strobe_n) begin
			cnt <= waits;
			busy <= 1'b0;
			if (bus_takeover && transfer_direction_out == DIR_READ) begin
				cur <= words[idx[1:0]];
				idx <= idx + 1;
				n_rd <= n_rd + 1;
				busy <= 1'b1;
			end else if (bus_takeover) begin
				n_wr <= n_wr + 1;
			end
		end else begin
			if (cnt != 4'h0) cnt <= cnt - 4'h1;
			if (!bus_takeover) busy <= 1'b0;
			if (bus_takeover && low_addr_data_oe && transfer_direction_out == DIR_WRITE)
				last_wr <= low_addr_data_out;
		end
	end
endmodule : mbs_mem_model

/* dv/mbs_seq_tb.sv */
`timescale 1ns/100ps
module mbs_seq_tb
	import mbs_pkg::*;
;
	localparam logic [VA_W-1:0] VA_A = 24'h0102a5;
	localparam logic [VA_W-1:0] VA_B = 24'h020400;
	localparam logic [VA_W-1:0] VA_C = 24'h030600;
	localparam logic [VA_W-1:0] VA_D = 24'h040800;
	localparam logic [VA_W-1:0] VA_E = 24'h050a00;
	logic sys_clk, nrst, addr_strobe_n, transfer_direction_in, user_mode;
	logic ready, bus_width_select, low_addr_data_oe, upper_address_oe;
	logic transfer_direction_out, transfer_direction_oe, phys_addr_strobe_n;
	logic bus_takeover, reset_abort_out_n, mode_16bit;
	logic [VA_W-1:0] cpu_vaddr;
	logic [3:0] cycle_status;
	logic [15:0] low_addr_data_in, low_addr_data_out;
	logic [8:0] upper_address_lines, pa_lo;
	int n_errors, samples_checked, cycles;
	int ps, nps, ab, nab, tk, tk_end, ua, doe, wk;

	mbs_seq dut_u (.hold_req(1'b0), .table_base(25'h0010000), .*);
	mbs_mem_model mem_u (.*);

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 2500) begin
			n_errors++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic do_reset(input logic wide);
		nrst = 1'b0;
		bus_width_select = wide;
		repeat (6) @(posedge sys_clk);
		#1;
		nrst = 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask : do_reset

	// one cpu access, then watch the device for a fixed window
	task automatic cpu_cycle(input logic [VA_W-1:0] va, input logic dir,
		input logic [3:0] st, input logic usr);
		addr_strobe_n = 1'b0;
		cpu_vaddr = va;
		transfer_direction_in = dir;
		cycle_status = st;
		user_mode = usr;
		{ps, nps, ab, nab, tk, tk_end, ua, doe, wk} = 288'h0;
		@(posedge sys_clk);
		#1;
		addr_strobe_n = 1'b1;
		for (int i = 1; i < 60; i++) begin
			if (!phys_addr_strobe_n && bus_takeover && wk == 0) wk = i;
			if (!phys_addr_strobe_n && !bus_takeover) begin
				ps = i;
				nps++;
				pa_lo = low_addr_data_out[8:0];
			end
			if (bus_takeover) begin
				if (tk == 0) tk = i;
				tk_end = i;
			end
			if (!reset_abort_out_n) begin
				ab = i;
				nab++;
			end
			if (ps != 0 && upper_address_oe && !bus_takeover) ua++;
			if (ps != 0 && i > ps && low_addr_data_oe) doe++;
			@(posedge sys_clk);
			#1;
		end
	endtask : cpu_cycle

	task automatic t_miss();
		mem_u.load(16'h0007, 16'h0000, 16'h0007, 16'h0012, 4'h0);
		check(mode_16bit, 8'h1);
		cpu_cycle(VA_A, DIR_READ, 4'ha, 1'b1);
		check(tk, 8'h2);
		check(wk, 8'h4);
		check(ps - wk, 8'h18);
		check(mem_u.n_rd, 8'h4);
		check(mem_u.n_wr, 8'h2);
		check(mem_u.last_wr, 16'h000f);
		check(tk_end, ps - 1);
		check(nps + nab, 8'h1);
		check(pa_lo, VA_A[8:0]);
	endtask : t_miss

	task automatic t_hit();
		int ua2;
		mem_u.load(16'h0000, 16'h0000, 16'h0000, 16'h0000, 4'h0);
		cpu_cycle(VA_A, DIR_READ, 4'h8, 1'b1);
		check(ps, 8'h2);
		check(tk, 8'h0);
		check(doe, 8'h0);
		check(ua, 8'h4);
		mem_u.load(16'h0000, 16'h0000, 16'h0000, 16'h0000, 4'h2);
		cpu_cycle(VA_A, DIR_READ, 4'hc, 1'b1);
		ua2 = ua;
		mem_u.load(16'h0000, 16'h0000, 16'h0000, 16'h0000, 4'h4);
		cpu_cycle(VA_A, DIR_READ, 4'h9, 1'b1);
		check(ua - ua2, 8'h2);
	endtask : t_hit

	task automatic t_wclean();
		mem_u.load(16'h000f, 16'h0000, 16'h000f, 16'h0012, 4'h0);
		cpu_cycle(VA_A, DIR_WRITE, 4'ha, 1'b1);
		check(tk, 8'h2);
		check(mem_u.n_wr, 8'h1);
		check(mem_u.last_wr, 16'h001f);
		check(nps, 8'h1);
		cpu_cycle(VA_A, DIR_WRITE, 4'ha, 1'b1);
		check(tk, 8'h0);
		check(ps, 8'h2);
	endtask : t_wclean

	task automatic t_forbid();
		mem_u.load(16'h0001, 16'h0000, 16'h0001, 16'h0020, 4'h0);
		cpu_cycle(VA_B, DIR_READ, 4'ha, 1'b0);
		check(nps, 8'h1);
		cpu_cycle(VA_B, DIR_READ, 4'ha, 1'b1);
		check(ab, 8'h2);
		check(nab, 8'h1);
		check(nps + tk, 8'h0);
	endtask : t_forbid

	task automatic t_rmw();
		mem_u.load(16'h0005, 16'h0000, 16'h0005, 16'h0030, 4'h0);
		cpu_cycle(VA_C, DIR_READ, 4'ha, 1'b1);
		check(nps, 8'h1);
		cpu_cycle(VA_C, DIR_READ, ST_RMW_READ, 1'b1);
		check(nab, 8'h1);
		check(nps, 8'h0);
		cpu_cycle(VA_C, DIR_WRITE, 4'ha, 1'b1);
		check(ab, 8'h3);
		check(tk, 8'h2);
		check(tk_end, 8'h3);
		check(nps, 8'h0);
	endtask : t_rmw

	task automatic t_invalid();
		mem_u.load(16'h0000, 16'h0000, 16'h0000, 16'h0000, 4'h0);
		cpu_cycle(VA_D, DIR_READ, 4'ha, 1'b1);
		check(mem_u.n_rd, 8'h1);
		check(mem_u.n_wr + nps, 8'h0);
		check(nab, 8'h1);
		check(tk_end, ab - 1);
	endtask : t_invalid

	task automatic t_wide32();
		do_reset(1'b0);
		check(mode_16bit, 8'h0);
		mem_u.load(16'h0007, 16'h0000, 16'h0007, 16'h0012, 4'h0);
		cpu_cycle(VA_E, DIR_READ, 4'ha, 1'b1);
		check(mem_u.n_rd, 8'h4);
		mem_u.load(16'h0000, 16'h0000, 16'h0000, 16'h0000, 4'h3);
		cpu_cycle(VA_E, DIR_READ, 4'ha, 1'b1);
		check(ps, 8'h2);
		check(ua, 8'h1);
	endtask : t_wide32

	initial begin
		n_errors = 0;
		samples_checked = 0;
		cycles = 0;
		addr_strobe_n = 1'b1;
		cpu_vaddr = 24'h000000;
		transfer_direction_in = 1'b0;
		cycle_status = 4'h0;
		user_mode = 1'b0;
		do_reset(1'b1);
		t_miss();
		t_hit();
		t_wclean();
		t_forbid();
		t_rmw();
		t_invalid();
		t_wide32();
		finish_test();
	end
endmodule : mbs_seq_tb
